// ---- logic/opmc_pkg.sv ----
// Contract
// - Pin high at reset release selects run.
// - Run fetches vector word, then executes there.
// - Pin low at reset release enters background.
// - Host entry command halts into background.
// - Halt instruction enters background mode.
// - Controller or trace breakpoint enters background.
// - Wait stops core, clocks and regulator on.
// - Stop halts clocks, regulator to standby.
// - Deep stop powers down part, keeps RAM.
// - Light stop keeps everything powered.
`default_nettype none
package opmc_pkg;
    localparam logic [15:0] VEC_HI_ADDR = 16'hFFFE;
    localparam logic [15:0] VEC_LO_ADDR = 16'hFFFF;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [3:0] {
        OPMC_RESET = 4'b0000,
        OPMC_SAMPLE = 4'b0001,
        OPMC_FETCH_HI = 4'b0011,
        OPMC_FETCH_LO = 4'b0010,
        OPMC_RUN = 4'b0110,
        OPMC_WAIT = 4'b0111,
        OPMC_STOP_DEEP = 4'b0101,
        OPMC_STOP_LIGHT = 4'b0100,
        OPMC_DEBUG_HALT_INSTRUCTION = 4'b1100
    } opmc_state_t;

    typedef struct packed {
        logic host_entry;
        logic halt_instr;
        logic ctrl_break;
        logic trace_break;
    } opmc_debug_halt_instruction_req_t;

    typedef struct packed {
        logic core_clk_en;
        logic sys_clk_en;
        logic reg_full;
        logic partial_pd;
        logic ram_retain;
    } opmc_power_t;
endpackage : opmc_pkg
`default_nettype wire

// ---- logic/opmc_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
// Two-flop synchroniser; the first stage is read only by the second.
module opmc_sync (
    input wire logic clk,
    input wire logic srst,
    input wire logic din,
    output logic dout
);
    logic s1_q;
    logic s2_q;
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
        end
        else
        begin
            s1_q <= din;
            s2_q <= s1_q;
        end
    end
    assign dout = s2_q;
endmodule : opmc_sync
`default_nettype wire

// ---- logic/opmc_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module opmc_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic mode_select_debug_pin,
    input wire opmc_pkg::opmc_debug_halt_instruction_req_t debug_halt_instruction_req,
    input wire logic wait_req,
    input wire logic stop_req,
    input wire logic stop_deep_sel,
    input wire logic wake_req,
    input wire logic debug_halt_instruction_exit,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    output logic mem_rd,
    output logic [15:0] mem_addr,
    output logic core_start,
    output logic [15:0] start_pc,
    output logic core_halt,
    output logic debug_halt_instruction_active,
    output logic run_active,
    output opmc_pkg::opmc_power_t power
);
    logic pin_sync;
    opmc_pkg::opmc_state_t st_q, st_d;
    logic [15:0] pc_q, pc_d;
    logic rd_q, rd_d;
    logic [15:0] addr_q, addr_d;
    logic start_q, start_d;
    logic halt_q, halt_d;
    logic bg_q, bg_d;
    logic run_q, run_d;
    opmc_pkg::opmc_power_t pw_q, pw_d;
    logic any_bg;
    logic [1:0] settle_q, settle_d;

    opmc_sync u_sync (
        .clk(clk),
        .srst(srst),
        .din(mode_select_debug_pin),
        .dout(pin_sync)
    );

    // Halt, breakpoint and host requests share one entry path.
    assign any_bg = debug_halt_instruction_req.host_entry | debug_halt_instruction_req.halt_instr
        | debug_halt_instruction_req.ctrl_break | debug_halt_instruction_req.trace_break;

    always_comb
    begin
        st_d = st_q;
        pc_d = pc_q;
        rd_d = 1'b0;
        addr_d = addr_q;
        start_d = 1'b0;
        case (st_q)
            // The synchroniser shows its reset value until it has refilled.
            opmc_pkg::OPMC_RESET:
            begin
                if (settle_q == 2'(opmc_pkg::SYNC_STAGES))
                    st_d = opmc_pkg::OPMC_SAMPLE;
            end
            // The pin is only looked at here, after reset release and after each wake from deep stop.
            opmc_pkg::OPMC_SAMPLE:
            begin
                if (pin_sync)
                begin
                    st_d = opmc_pkg::OPMC_FETCH_HI;
                    rd_d = 1'b1;
                    addr_d = opmc_pkg::VEC_HI_ADDR;
                end
                else
                begin
                    st_d = opmc_pkg::OPMC_DEBUG_HALT_INSTRUCTION;
                end
            end
            opmc_pkg::OPMC_FETCH_HI:
            begin
                rd_d = ~mem_ack;
                if (mem_ack)
                begin
                    pc_d[15:8] = mem_rdata;
                    st_d = opmc_pkg::OPMC_FETCH_LO;
                    rd_d = 1'b1;
                    addr_d = opmc_pkg::VEC_LO_ADDR;
                end
            end
            opmc_pkg::OPMC_FETCH_LO:
            begin
                rd_d = ~mem_ack;
                if (mem_ack)
                begin
                    pc_d[7:0] = mem_rdata;
                    st_d = opmc_pkg::OPMC_RUN;
                    start_d = 1'b1;
                end
            end
            opmc_pkg::OPMC_RUN:
            begin
                if (any_bg)
                    st_d = opmc_pkg::OPMC_DEBUG_HALT_INSTRUCTION;
                else if (stop_req)
                    st_d = stop_deep_sel ? opmc_pkg::OPMC_STOP_DEEP
                        : opmc_pkg::OPMC_STOP_LIGHT;
                else if (wait_req)
                    st_d = opmc_pkg::OPMC_WAIT;
            end
            opmc_pkg::OPMC_WAIT:
            begin
                if (any_bg)
                    st_d = opmc_pkg::OPMC_DEBUG_HALT_INSTRUCTION;
                else if (wake_req)
                    st_d = opmc_pkg::OPMC_RUN;
            end
            // Deep stop loses core state, so waking goes through reset.
            opmc_pkg::OPMC_STOP_DEEP:
                if (wake_req)
                    st_d = opmc_pkg::OPMC_RESET;
            opmc_pkg::OPMC_STOP_LIGHT:
                if (wake_req)
                    st_d = opmc_pkg::OPMC_RUN;
            opmc_pkg::OPMC_DEBUG_HALT_INSTRUCTION:
                if (debug_halt_instruction_exit)
                    st_d = opmc_pkg::OPMC_RUN;
            default:
                st_d = opmc_pkg::OPMC_RESET;
        endcase
    end

    always_comb
    begin
        settle_d = 2'h0;
        if (st_q == opmc_pkg::OPMC_RESET
            && settle_q != 2'(opmc_pkg::SYNC_STAGES))
            settle_d = settle_q + 2'h1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            settle_q <= 2'h0;
        else
            settle_q <= settle_d;
    end

    always_comb
    begin
        halt_d = (st_d != opmc_pkg::OPMC_RUN);
        bg_d = (st_d == opmc_pkg::OPMC_DEBUG_HALT_INSTRUCTION);
        run_d = (st_d == opmc_pkg::OPMC_RUN);
        pw_d.core_clk_en = (st_d != opmc_pkg::OPMC_WAIT)
            && (st_d != opmc_pkg::OPMC_STOP_DEEP)
            && (st_d != opmc_pkg::OPMC_STOP_LIGHT);
        pw_d.sys_clk_en = (st_d != opmc_pkg::OPMC_STOP_DEEP)
            && (st_d != opmc_pkg::OPMC_STOP_LIGHT);
        pw_d.reg_full = pw_d.sys_clk_en;
        pw_d.partial_pd = (st_d == opmc_pkg::OPMC_STOP_DEEP);
        pw_d.ram_retain = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_q <= opmc_pkg::OPMC_RESET;
            pc_q <= 16'h0000;
            rd_q <= 1'b0;
            addr_q <= 16'h0000;
            start_q <= 1'b0;
            halt_q <= 1'b1;
            bg_q <= 1'b0;
            run_q <= 1'b0;
            pw_q <= 5'b1_1101;
        end
        else
        begin
            st_q <= st_d;
            pc_q <= pc_d;
            rd_q <= rd_d;
            addr_q <= addr_d;
            start_q <= start_d;
            halt_q <= halt_d;
            bg_q <= bg_d;
            run_q <= run_d;
            pw_q <= pw_d;
        end
    end

    assign mem_rd = rd_q;
    assign mem_addr = addr_q;
    assign core_start = start_q;
    assign start_pc = pc_q;
    assign core_halt = halt_q;
    assign debug_halt_instruction_active = bg_q;
    assign run_active = run_q;
    assign power = pw_q;

    sample_run_a: assert property (@(posedge clk) disable iff (srst)
        st_q == opmc_pkg::OPMC_SAMPLE && pin_sync
        |=> st_q == opmc_pkg::OPMC_FETCH_HI)
        else $error("high pin did not start vector fetch");
    sample_debug_halt_instruction_a: assert property (@(posedge clk) disable iff (srst)
        st_q == opmc_pkg::OPMC_SAMPLE && !pin_sync
        |=> ##1 debug_halt_instruction_active)
        else $error("low pin did not enter background");
    vector_addr_a: assert property (@(posedge clk) disable iff (srst)
        st_q == opmc_pkg::OPMC_FETCH_LO && mem_ack
        |=> core_start && start_pc[7:0] == $past(mem_rdata))
        else $error("start address wrong");
    bg_entry_a: assert property (@(posedge clk) disable iff (srst)
        st_q == opmc_pkg::OPMC_RUN && any_bg
        |=> debug_halt_instruction_active && core_halt)
        else $error("debug request not honoured");
    halt_instr_a: assert property (@(posedge clk) disable iff (srst)
        st_q == opmc_pkg::OPMC_WAIT && debug_halt_instruction_req.halt_instr
        |=> debug_halt_instruction_active)
        else $error("halt instruction ignored");
    break_entry_a: assert property (@(posedge clk) disable iff (srst)
        st_q == opmc_pkg::OPMC_RUN
        && (debug_halt_instruction_req.ctrl_break || debug_halt_instruction_req.trace_break)
        |=> st_q == opmc_pkg::OPMC_DEBUG_HALT_INSTRUCTION)
        else $error("breakpoint ignored");
    wait_pw_a: assert property (@(posedge clk) disable iff (srst)
        st_q == opmc_pkg::OPMC_WAIT |-> !power.core_clk_en
        && power.sys_clk_en && power.reg_full)
        else $error("wait power state wrong");
    stop_pw_a: assert property (@(posedge clk) disable iff (srst)
        st_q == opmc_pkg::OPMC_STOP_DEEP || st_q == opmc_pkg::OPMC_STOP_LIGHT
        |-> !power.sys_clk_en && !power.reg_full)
        else $error("stop power state wrong");
    deep_pw_a: assert property (@(posedge clk) disable iff (srst)
        st_q == opmc_pkg::OPMC_STOP_DEEP
        |-> power.partial_pd && power.ram_retain)
        else $error("deep stop power wrong");
    light_pw_a: assert property (@(posedge clk) disable iff (srst)
        st_q == opmc_pkg::OPMC_STOP_LIGHT |-> !power.partial_pd)
        else $error("light stop powered down");
    pin_ignored_a: assert property (@(posedge clk) disable iff (srst)
        st_q == opmc_pkg::OPMC_RUN && !any_bg && !stop_req && !wait_req
        |=> st_q == opmc_pkg::OPMC_RUN)
        else $error("pin changed mode after reset");
    sync_settle_a: assert property (@(posedge clk) disable iff (srst)
        st_q == opmc_pkg::OPMC_RESET
        && settle_q != 2'(opmc_pkg::SYNC_STAGES)
        |=> st_q == opmc_pkg::OPMC_RESET)
        else $error("pin sampled before synchroniser filled");

    run_cov: cover property (@(posedge clk) core_start);
    debug_halt_instruction_cov: cover property (@(posedge clk) debug_halt_instruction_active && !srst);
    deep_cov: cover property (@(posedge clk) st_q == opmc_pkg::OPMC_STOP_DEEP);
    wait_cov: cover property (@(posedge clk) st_q == opmc_pkg::OPMC_WAIT);
endmodule : opmc_top
`default_nettype wire

// ---- testbench/opmc_mem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Vector memory; data off the acknowledge cycle is scrambled on purpose.
module opmc_mem_model (
    input wire logic clk,
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] vec_hi,
    input wire logic [7:0] vec_lo,
    input wire logic [3:0] lat,
    output logic mem_ack,
    output logic [7:0] mem_rdata
);
    logic [3:0] cnt = 4'h0;
    logic cool = 1'b0;
    initial
    begin
        mem_ack = 1'b0;
        mem_rdata = 8'h00;
    end
    // A dead cycle after each acknowledge keeps one read from being served twice.
    always @(posedge clk)
    begin
        #1;
        mem_ack = 1'b0;
        mem_rdata = ~mem_rdata;
        if (cool || !mem_rd)
        begin
            cool = 1'b0;
            cnt = 4'h0;
        end
        else if (cnt == lat)
        begin
            mem_ack = 1'b1;
            mem_rdata = (mem_addr == opmc_pkg::VEC_HI_ADDR) ? vec_hi :
                (mem_addr == opmc_pkg::VEC_LO_ADDR) ? vec_lo : 8'h00;
            cool = 1'b1;
        end
        else
            cnt = cnt + 4'h1;
    end
endmodule : opmc_mem_model
`default_nettype wire

// ---- testbench/tb_operating_mode_control.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_operating_mode_control;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic mode_select_debug_pin = 1'b1;
    opmc_pkg::opmc_debug_halt_instruction_req_t debug_halt_instruction_req = '0;
    logic wait_req = 1'b0;
    logic stop_req = 1'b0;
    logic stop_deep_sel = 1'b0;
    logic wake_req = 1'b0;
    logic debug_halt_instruction_exit = 1'b0;
    logic mem_ack, mem_rd, core_start, core_halt, debug_halt_instruction_active, run_active;
    logic [7:0] mem_rdata;
    logic [7:0] vec_hi = 8'h00;
    logic [7:0] vec_lo = 8'h00;
    logic [3:0] lat = 4'h0;
    logic [15:0] mem_addr, start_pc;
    opmc_pkg::opmc_power_t power;
    int n_errors = 0;
    int samples_checked = 0;
    int n_start = 0;
    int cycles = 0;

    opmc_top dut (.clk, .srst, .mode_select_debug_pin, .debug_halt_instruction_req, .wait_req,
        .stop_req, .stop_deep_sel, .wake_req, .debug_halt_instruction_exit, .mem_ack,
        .mem_rdata, .mem_rd, .mem_addr, .core_start, .start_pc, .core_halt,
        .debug_halt_instruction_active, .run_active, .power);
    opmc_mem_model mem (.clk, .mem_rd, .mem_addr, .vec_hi, .vec_lo, .lat,
        .mem_ack, .mem_rdata);

    always #4 clk = ~clk;

    task final_report;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    // The ceiling is several times the length of the whole sequence.
    always @(posedge clk)
    begin
        cycles++;
        if (core_start === 1'b1)
            n_start++;
        if (cycles == 2000)
        begin
            n_errors++;
            $display("unexpected at %0t: timeout", $time);
            final_report();
        end
    end

    task check_v(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check_v

    task check_pwr(input opmc_pkg::opmc_power_t got, input logic [4:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: power %b want %b", $time, got, exp);
        end
    endtask : check_pwr

    task step;
        @(posedge clk);
        #1;
        debug_halt_instruction_req = '0;
        {wait_req, stop_req, wake_req, debug_halt_instruction_exit} = 4'h0;
        @(posedge clk);
        #1;
    endtask : step

    task settle;
        for (int i = 0; i < 40; i++)
        begin
            if (run_active === 1'b1 || debug_halt_instruction_active === 1'b1)
                break;
            @(posedge clk);
            #1;
        end
        // One more edge so the start pulse is counted.
        @(posedge clk);
        #1;
    endtask : settle

    task boot(input logic pin, input logic [7:0] hi, lo, input logic [3:0] l);
        int n;
        n = n_start;
        mode_select_debug_pin = pin;
        {vec_hi, vec_lo, lat} = {hi, lo, l};
        srst = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        srst = 1'b0;
        settle();
        check_v(run_active, pin);
        check_v(debug_halt_instruction_active, !pin);
        check_v(16'(n_start - n), pin);
        if (pin)
            check_v(start_pc, {hi, lo});
        check_v(mem_rd, 16'h0000);
    endtask : boot

    task pin_ignored;
        mode_select_debug_pin = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        check_v(run_active, 16'h0001);
        check_pwr(power, 5'h1d);
        mode_select_debug_pin = 1'b1;
    endtask : pin_ignored

    task enter_debug_halt_instruction;
        for (int k = 0; k < 4; k++)
        begin
            debug_halt_instruction_req = 4'h8 >> k;
            step();
            check_v({debug_halt_instruction_active, run_active, core_halt}, 16'h0005);
            debug_halt_instruction_exit = 1'b1;
            step();
            check_v({run_active, core_halt}, 16'h0002);
        end
    endtask : enter_debug_halt_instruction

    task wait_mode;
        wait_req = 1'b1;
        step();
        check_pwr(power, 5'h0d);
        check_v(core_halt, 16'h0001);
        wake_req = 1'b1;
        step();
        check_v(run_active, 16'h0001);
        wait_req = 1'b1;
        step();
        debug_halt_instruction_req = 4'h4;
        step();
        check_v(debug_halt_instruction_active, 16'h0001);
        debug_halt_instruction_exit = 1'b1;
        step();
        check_v(run_active, 16'h0001);
    endtask : wait_mode

    task stop_mode(input logic deep);
        int n;
        {stop_req, wait_req, stop_deep_sel} = {2'b11, deep};
        step();
        check_pwr(power, deep ? 5'h03 : 5'h01);
        debug_halt_instruction_req = 4'h8;
        step();
        check_v(debug_halt_instruction_active, 16'h0000);
        n = n_start;
        {vec_hi, vec_lo, lat} = {8'h5a, 8'hc3, 4'h3};
        wake_req = 1'b1;
        step();
        settle();
        check_v(run_active, 16'h0001);
        if (deep)
            check_v(start_pc, 16'h5ac3);
        check_v(16'(n_start - n), deep);
    endtask : stop_mode

    initial
    begin
        boot(1'b1, 8'ha5, 8'h3c, 4'h0);
        pin_ignored();
        enter_debug_halt_instruction();
        wait_mode();
        stop_mode(1'b0);
        stop_mode(1'b1);
        boot(1'b0, 8'h00, 8'h00, 4'h0);
        boot(1'b1, 8'h12, 8'h34, 4'h2);
        final_report();
    end
endmodule : tb_operating_mode_control
`default_nettype wire
